// file: src/aicr_pkg.sv
/*
 * Package for the analog input control register bank: subaddresses,
 * field positions, reset values and decoded mode enumerations.
 * Assumes an upstream serial-bus slave that presents byte writes and reads.
 */
package aicr_pkg;

    // ------------------------------------------------------------------
    // subaddresses
    // ------------------------------------------------------------------
    localparam logic [7:0] SUB_CHIP_VERSION = 8'h00;
    localparam logic [7:0] SUB_INCR_DELAY   = 8'h01;
    localparam logic [7:0] SUB_AIN_CTRL_ONE = 8'h02;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CHIP_VERSION_LSB = 4;
    localparam int WHITE_PEAK_BIT   = 6;
    localparam int GAIN_HYST_LSB    = 4;
    localparam int INCR_DELAY_LSB   = 0;
    localparam int FUNC_SEL_LSB     = 6;
    localparam int MODE_LSB         = 0;

    // ------------------------------------------------------------------
    // reset values and special codes
    // ------------------------------------------------------------------
    localparam logic [6:0] INCR_DELAY_REG_RST = 7'h00;
    localparam logic [7:0] AIN_CTRL_REG_RST   = 8'h00;
    localparam logic [3:0] INCR_DELAY_NO_UPD  = 4'hF;
    localparam logic [5:0] MODE_CVBS_LAST     = 6'h05;
    localparam logic [5:0] MODE_YC_LAST       = 6'h0D;

    // ------------------------------------------------------------------
    // decoded types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        AICR_FUNC_BYPASS     = 2'b00,
        AICR_FUNC_AMP        = 2'b10,
        AICR_FUNC_AMP_FILTER = 2'b11
    } aicr_func_e;

    typedef enum logic [1:0] {
        AICR_PATH_NONE = 2'b00,
        AICR_PATH_CVBS = 2'b01,
        AICR_PATH_YC   = 2'b10
    } aicr_path_e;

endpackage : aicr_pkg

// file: src/aicr_mode_decode.sv
/*
 * Decoder from the six-bit input mode code to source selections.
 * Assumes a registered mode code on the same clock; purely combinational.
 */
`timescale 1ns/10ps
module aicr_mode_decode (
    input  wire logic [5:0]          mode_i,        // input mode code
    output aicr_pkg::aicr_path_e     path_o,        // cvbs, y/c or none
    output logic [1:0]               luma_group_o,  // 0: none, 1: group 1, 2: group 2
    output logic [2:0]               luma_input_o,  // input 1..4 inside group, 0 none
    output logic [2:0]               chroma_input_o,// group 2 input 1..4, 0 none
    output logic                     chroma_track_o // chroma gain follows luma gain
);
    import aicr_pkg::*;

    logic [5:0] yc_idx;
    logic [1:0] pair_n;

    always_comb begin
        yc_idx         = mode_i - 6'h06;
        pair_n         = {yc_idx[2], yc_idx[0]};
        path_o         = AICR_PATH_NONE;
        luma_group_o   = 2'd0;
        luma_input_o   = 3'd0;
        chroma_input_o = 3'd0;
        chroma_track_o = 1'b0;
        if (mode_i <= MODE_CVBS_LAST) begin
            path_o = AICR_PATH_CVBS;
            if (mode_i < 6'h02) begin
                luma_group_o = 2'd1;
                luma_input_o = 3'(mode_i) + 3'd1;
            end else begin
                luma_group_o = 2'd2;
                luma_input_o = 3'(mode_i) - 3'd1;
            end
        end else if (mode_i <= MODE_YC_LAST) begin
            // pairs n=1..4; bit1 of the offset picks tracked chroma gain
            path_o         = AICR_PATH_YC;
            luma_group_o   = 2'd1;
            luma_input_o   = {1'b0, pair_n} + 3'd1;
            chroma_input_o = {1'b0, pair_n} + 3'd1;
            chroma_track_o = yc_idx[1];
        end
    end

endmodule : aicr_mode_decode

// file: src/aicr_regs.sv
/*
 * Analog input control register bank, subaddresses 00h to 02h.
 * Assumes a serial-bus slave in front that issues single-cycle write and
 * read strobes with a subaddress, synchronous to sys_clk_i.
 */
// How it works
// - read-only version nibble at 00h[7:4]
// - white peak limit active when bit clear
// - bits 5:4 set gain update hysteresis
// - delay code 1110 minimal, 0000 maximal, 1111 no update
// - bits 7:6 select amplifier and filter
// - modes 00-05 select six composite inputs
// - y/c pairs with static chroma gain
// - y/c pairs with tracked chroma gain
`timescale 1ns/10ps
module aicr_regs #(
    parameter logic [3:0] CHIP_VERSION = 4'h1   // arbitrary value
) (
    input  wire logic                 sys_clk_i,          // 40 MHz clock
    input  wire logic                 sys_rst_i,          // sync reset, active high
    input  wire logic [7:0]           sub_addr_i,         // register subaddress
    input  wire logic                 wr_en_i,            // write strobe
    input  wire logic [7:0]           wr_data_i,          // write data
    input  wire logic                 rd_en_i,            // read strobe
    output logic [7:0]                rd_data_o,          // read data, registered
    output logic                      rd_valid_o,         // read data valid pulse
    output logic                      white_peak_limit_o, // limiter enabled
    output logic [1:0]                gain_update_hysteresis_o, // hysteresis, bits 5:4
    output logic [3:0]                increment_delay_o,  // delay code
    output logic                      increment_delay_upd_o, // delay update enabled
    output logic                      amp_enable_o,       // amplifier active
    output logic                      aa_filter_enable_o, // anti-alias filter active
    output aicr_pkg::aicr_path_e      input_path_o,       // selected path type
    output logic [1:0]                luma_group_o,       // luma input group
    output logic [2:0]                luma_input_o,       // luma input number
    output logic [2:0]                chroma_input_o,     // chroma input number
    output logic                      chroma_track_o,     // chroma gain tracks luma
    output logic                      chroma_static_gain_o // chroma from static gain
);
    import aicr_pkg::*;

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic [6:0] incr_delay_ctrl_r;
    logic [7:0] ain_ctrl_one_r;
    logic [7:0] rd_data_r;
    logic       rd_valid_r;

    // a write strobe only counts for the subaddress that it names
    function automatic logic write_hit(input logic       wr_en,
                                       input logic [7:0] addr,
                                       input logic [7:0] target);
        return wr_en && (addr == target);
    endfunction : write_hit

    // bit 7 of 01h is unused, so it is not stored and reads zero
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            incr_delay_ctrl_r <= INCR_DELAY_REG_RST;
        end else if (write_hit(wr_en_i, sub_addr_i, SUB_INCR_DELAY)) begin
            incr_delay_ctrl_r <= wr_data_i[6:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            ain_ctrl_one_r <= AIN_CTRL_REG_RST;
        end else if (write_hit(wr_en_i, sub_addr_i, SUB_AIN_CTRL_ONE)) begin
            ain_ctrl_one_r <= wr_data_i;
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    function automatic logic [7:0] read_mux(input logic [7:0] addr);
        logic [7:0] val;
        val = 8'h00;
        if (addr == SUB_CHIP_VERSION) begin
            val = {CHIP_VERSION, 4'h0};
        end else if (addr == SUB_INCR_DELAY) begin
            val = {1'b0, incr_delay_ctrl_r};
        end else if (addr == SUB_AIN_CTRL_ONE) begin
            val = ain_ctrl_one_r;
        end
        return val;
    endfunction : read_mux

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            rd_data_r  <= 8'h00;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= rd_en_i;
            if (rd_en_i) begin
                rd_data_r <= read_mux(sub_addr_i);
            end
        end
    end

    assign rd_data_o  = rd_data_r;
    assign rd_valid_o = rd_valid_r;

    // ------------------------------------------------------------------
    // control decode
    // ------------------------------------------------------------------
    logic [1:0] func_sel;
    logic [3:0] delay_code;

    assign func_sel   = ain_ctrl_one_r[FUNC_SEL_LSB +: 2];
    assign delay_code = incr_delay_ctrl_r[INCR_DELAY_LSB +: 4];

    assign white_peak_limit_o       = ~incr_delay_ctrl_r[WHITE_PEAK_BIT];
    assign gain_update_hysteresis_o = incr_delay_ctrl_r[GAIN_HYST_LSB +: 2];
    // lower code means longer delay; the analog side consumes the raw code
    assign increment_delay_o        = delay_code;
    assign increment_delay_upd_o    = (delay_code != INCR_DELAY_NO_UPD);

    // 01 is undefined; treated as bypass so nothing switches on by accident
    assign amp_enable_o       = (func_sel == AICR_FUNC_AMP) ||
                                (func_sel == AICR_FUNC_AMP_FILTER);
    assign aa_filter_enable_o = (func_sel == AICR_FUNC_AMP_FILTER);

    // ------------------------------------------------------------------
    // input mode routing
    // ------------------------------------------------------------------
    logic track;

    aicr_mode_decode u_mode_decode (
        .mode_i         (ain_ctrl_one_r[MODE_LSB +: 6]),
        .path_o         (input_path_o),
        .luma_group_o   (luma_group_o),
        .luma_input_o   (luma_input_o),
        .chroma_input_o (chroma_input_o),
        .chroma_track_o (track)
    );

    assign chroma_track_o       = track;
    assign chroma_static_gain_o = (input_path_o == AICR_PATH_YC) && !track;

endmodule : aicr_regs

// file: testbench/aicr_regs_asserts.sv
/* checker for the analog input control registers.
   bound to aicr_regs below; sees only that module's ports. */
`timescale 1ns/10ps
module aicr_regs_asserts #(
    parameter logic [3:0] CHIP_VERSION = 4'h1 // arbitrary value
) (
    input wire logic sys_clk_i, sys_rst_i, wr_en_i, rd_en_i,       // control
    input wire logic [7:0] sub_addr_i, wr_data_i, rd_data_o,        // bytes
    input wire logic rd_valid_o, white_peak_limit_o, amp_enable_o,  // flags
    input wire logic aa_filter_enable_o, increment_delay_upd_o,     // flags
    input wire logic chroma_track_o, chroma_static_gain_o,          // flags
    input wire logic [3:0] increment_delay_o,                       // delay
    input wire logic [1:0] gain_update_hysteresis_o,                // hysteresis
    input wire aicr_pkg::aicr_path_e input_path_o                   // path
);
    import aicr_pkg::*;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    wire w1 = wr_en_i && sub_addr_i == SUB_INCR_DELAY;
    wire w2 = wr_en_i && sub_addr_i == SUB_AIN_CTRL_ONE;
    rd_pulse_a: assert property (rd_valid_o == $past(rd_en_i))
        else $error("read valid misplaced");
    ver_read_a: assert property (rd_en_i && sub_addr_i == SUB_CHIP_VERSION
        |=> rd_data_o == {CHIP_VERSION, 4'h0}) else $error("version read wrong");
    peak_ctrl_a: assert property (w1 |=> white_peak_limit_o == !$past(wr_data_i[6]))
        else $error("white peak wrong");
    gain_hyst_a: assert property (w1
        |=> gain_update_hysteresis_o == $past(wr_data_i[5:4])) else $error("hysteresis wrong");
    delay_code_a: assert property (w1 |=> increment_delay_o == $past(wr_data_i[3:0])
        && increment_delay_upd_o == ($past(wr_data_i[3:0]) != 4'hF)) else $error("delay wrong");
    delay_hold_a: assert property (!w1 |=> $stable(increment_delay_o))
        else $error("delay changed without write");
    func_sel_a: assert property (w2 |=> amp_enable_o == $past(wr_data_i[7])
        && aa_filter_enable_o == &$past(wr_data_i[7:6])) else $error("function wrong");
    cvbs_mode_a: assert property (w2 && wr_data_i[5:0] <= MODE_CVBS_LAST
        |=> input_path_o == AICR_PATH_CVBS) else $error("composite path wrong");
    yc_static_a: assert property (w2 && wr_data_i[5:0] inside {6'h06, 6'h07, 6'h0A, 6'h0B}
        |=> chroma_static_gain_o && !chroma_track_o && input_path_o == AICR_PATH_YC)
        else $error("static gain wrong");
    yc_track_a: assert property (w2 && wr_data_i[5:0] inside {6'h08, 6'h09, 6'h0C, 6'h0D}
        |=> chroma_track_o && input_path_o == AICR_PATH_YC) else $error("tracking wrong");
    reset_val_a: assert property ($past(sys_rst_i) |-> white_peak_limit_o
        && !amp_enable_o && increment_delay_o == 4'h0) else $error("reset value wrong");
    cover property (w2 && wr_data_i[7:6] == 2'b11);
    cover property (w1 && wr_data_i[3:0] == 4'hF);
    cover property (rd_en_i && sub_addr_i == SUB_CHIP_VERSION);
endmodule : aicr_regs_asserts

bind aicr_regs aicr_regs_asserts #(.CHIP_VERSION(CHIP_VERSION)) i_aicr_regs_asserts (
    .sys_clk_i, .sys_rst_i, .wr_en_i, .rd_en_i, .sub_addr_i, .wr_data_i, .rd_data_o,
    .rd_valid_o, .white_peak_limit_o, .amp_enable_o, .aa_filter_enable_o,
    .increment_delay_upd_o, .chroma_track_o, .chroma_static_gain_o, .increment_delay_o,
    .gain_update_hysteresis_o, .input_path_o);

// file: testbench/aicr_host_model.sv
/* host side model: issues byte write and read strobes to the bank.
   assumes tasks are called from one bench process only. */
`timescale 1ns/10ps
module aicr_host_model (
    input  wire logic       sys_clk_i,          // clock
    input  wire logic [7:0] rd_data_i,          // read data
    input  wire logic       rd_valid_i,         // read valid
    output logic      [7:0] sub_addr_o = 8'h00, // subaddress
    output logic            wr_en_o = 1'b0,     // write strobe
    output logic      [7:0] wr_data_o = 8'h00,  // write data
    output logic            rd_en_o = 1'b0      // read strobe
);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        sub_addr_o <= a;
        wr_data_o  <= (a == 8'h01) ? {1'b0, d[6:0]} : d;
        wr_en_o    <= 1'b1;
        @(posedge sys_clk_i);
        wr_en_o    <= 1'b0;
        wr_data_o  <= ~d; // released bus shows no stale value
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic v);
        @(posedge sys_clk_i);
        sub_addr_o <= a;
        rd_en_o    <= 1'b1;
        @(posedge sys_clk_i);
        rd_en_o    <= 1'b0;
        @(negedge sys_clk_i);
        q = rd_data_i;
        v = rd_valid_i;
    endtask : rd
endmodule : aicr_host_model

// file: testbench/aicr_regs_tb_top.sv
/* bench for aicr_regs: host model drives strobes, integer model predicts.
   assumes aicr_pkg and the checker are compiled before it. */
`timescale 1ns/10ps
module aicr_regs_tb_top;
    import aicr_pkg::*;
    localparam logic [3:0] VERSION = 4'h5; // arbitrary value
    logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, wr_en_i, rd_en_i, rd_valid_o, v;
    logic white_peak_limit_o, increment_delay_upd_o, amp_enable_o, aa_filter_enable_o;
    logic chroma_track_o, chroma_static_gain_o;
    logic [7:0] sub_addr_i, wr_data_i, rd_data_o, q;
    logic [1:0] gain_update_hysteresis_o, luma_group_o;
    logic [3:0] increment_delay_o;
    logic [2:0] luma_input_o, chroma_input_o;
    aicr_path_e input_path_o;
    int fails = 0, comparisons = 0, cycles = 0, seed = 33385, r1 = 0, r2 = 0;
    wire [23:0] outs = {2'b00, white_peak_limit_o, gain_update_hysteresis_o, increment_delay_o,
        increment_delay_upd_o, amp_enable_o, aa_filter_enable_o, input_path_o, luma_group_o,
        luma_input_o, chroma_input_o, chroma_track_o, chroma_static_gain_o};
    aicr_regs #(.CHIP_VERSION(VERSION)) i_aicr_regs (.sys_clk_i, .sys_rst_i, .sub_addr_i,
        .wr_en_i, .wr_data_i, .rd_en_i, .rd_data_o, .rd_valid_o, .white_peak_limit_o,
        .gain_update_hysteresis_o, .increment_delay_o, .increment_delay_upd_o, .amp_enable_o,
        .aa_filter_enable_o, .input_path_o, .luma_group_o, .luma_input_o, .chroma_input_o,
        .chroma_track_o, .chroma_static_gain_o);
    aicr_host_model i_aicr_host_model (.sys_clk_i, .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o),
        .sub_addr_o(sub_addr_i), .wr_en_o(wr_en_i), .wr_data_o(wr_data_i), .rd_en_o(rd_en_i));
    initial forever #12.5 sys_clk_i = ~sys_clk_i;
    function automatic logic [23:0] expect_out();
        int m, i, n, p, g, li, ci;
        m  = r2 & 63;
        i  = m - 6;
        n  = (i & 1) + 1 + (i >> 2) * 2;
        p  = m <= 5 ? 1 : (m <= 13 ? 2 : 0);
        g  = p == 1 ? (m < 2 ? 1 : 2) : (p == 2 ? 1 : 0);
        li = p == 1 ? (m < 2 ? m + 1 : m - 1) : (p == 2 ? n : 0);
        ci = p == 2 ? n : 0;
        return {2'b00, !r1[6], r1[5:4], r1[3:0], r1[3:0] != 4'hF, r2[7], r2[7:6] == 2'b11,
            p[1:0], g[1:0], li[2:0], ci[2:0], p == 2 && i[1], p == 2 && !i[1]};
    endfunction : expect_out
    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    // write through the host, mirror it in the integer model, compare controls
    task automatic put(input int a, input int d);
        i_aicr_host_model.wr(a[7:0], d[7:0]);
        if (a == 1) r1 = d & 127;
        if (a == 2) r2 = d & 255;
        @(negedge sys_clk_i);
        chk(outs, expect_out(), "controls");
    endtask : put
    task automatic get(input int a, input int e);
        i_aicr_host_model.rd(a[7:0], q, v);
        chk({15'h0000, v, q}, {16'h0001, e[7:0]}, "read");
    endtask : get
    task automatic final_report();
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        repeat (3) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        @(negedge sys_clk_i);
        chk(outs, expect_out(), "reset");
        put(0, 8'hFF);
        get(0, {VERSION, 4'h0});
        for (int k = 0; k < 16; k++) begin
            put(1, ($random(seed) & 8'hF0) | k);
            get(1, r1);
        end
        for (int k = 0; k < 64; k++) begin
            put(2, ($random(seed) & 8'hC0) | k);
            get(2, r2);
        end
        // mid-run reset must clear the random values left in both registers
        @(posedge sys_clk_i);
        sys_rst_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        r1 = 0;
        r2 = 0;
        @(negedge sys_clk_i);
        chk(outs, expect_out(), "reset");
        get(1, 0);
        get(2, 0);
        // leave the host setting: recommended delay code, limiter off
        put(1, 8'h47);
        get(1, 8'h47);
        put(3, 8'hAA);
        get(3, 0);
        final_report();
    end
endmodule : aicr_regs_tb_top
